//--- rtl/apm_pkg.sv
/*
  Package for the axis position mode configuration block: field positions,
  unit codes, reset values and decode widths.
  Assumes a single clock and an asynchronous active-high reset.
*/
package apm_pkg;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int unsigned APM_SEL_BIT = 7;     // command selection, fixed word
  localparam int unsigned APM_CODE_EN_BIT = 8; // command code enable, run mode word
  localparam int unsigned APM_REFTYPE_BIT = 14; // reference type, run control word
  localparam int unsigned APM_UNIT_LSB = 0;
  localparam int unsigned APM_UNIT_W = 4;
  localparam int unsigned APM_GEAR_BIT = 4;    // gear enable, function flags
  localparam int unsigned APM_DIGITS_W = 3;
  localparam logic [2:0] APM_DIGITS_MAX = 3'h5;

  // ----------------------------------------------------------------------
  // reference unit codes
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    APM_UNIT_PULSE = 4'h0,
    APM_UNIT_MM = 4'h1,
    APM_UNIT_DEG = 4'h2,
    APM_UNIT_INCH = 4'h3
  } apm_unit_t;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [3:0] APM_RST_UNIT = 4'h0;
  localparam logic [2:0] APM_RST_DIGITS = 3'h0;
  localparam logic [1:0] APM_POS_LAT = 2'h2; // input sync stages, cycles; the state flop adds one more before the output

  // servo states
  typedef enum logic [1:0] {
    APM_ST_IDLE = 2'b00,
    APM_ST_MOVE = 2'b01,
    APM_ST_CLAMP = 2'b10
  } apm_state_t;

endpackage : apm_pkg

//--- rtl/apm_sync.sv
/*
  Two-flop synchroniser, one per bit, for inputs from outside the clock.
  Assumes the destination clock is the controller clock.
*/
`timescale 1ns/10ps
module apm_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // ----------------------------------------------------------------------
  // per-bit two-stage sampling
  // ----------------------------------------------------------------------
  generate
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      // first stage feeds only the second
      always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
          stage1[i] <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          stage1[i] <= async_in[i];
          sync_out[i] <= stage1[i];
        end
      end
    end
  endgenerate

endmodule : apm_sync

//--- rtl/apm_mode_cfg.sv
/*
  Mode decode for one servo axis's position control: whether the motion
  command word drives the axis, the reference unit and resolution, the
  features that follow, and a move/stop/clamp servo state.
  Assumes parameter words arrive from user program logic, and the encoder
  and servo status bits arrive from pins, so they are synchronised here.
*/
// Operation
// - commands run only when both enable bits set
// - decode unit code: pulse, mm, deg, inch
// - resolution is ten to minus digits, pulse stays
// - no commands forces pulse unit
// - wrapping infinite axis only with commands
// - one-direction infinite axis in both modes
// - incremental mode only with commands, else absolute
// - move to target, stop, then servo clamp
// - absolute encoder keeps position, no zero return
`timescale 1ns/10ps
module apm_mode_cfg
  import apm_pkg::*;
#(
  parameter int unsigned DIGITS_W = APM_DIGITS_W
) (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic [15:0] fixed_add_func_in,
  input wire logic [15:0] fixed_func_flags_in,
  input wire logic [DIGITS_W-1:0] fixed_digits_in,
  input wire logic [15:0] run_mode_setting_word_in,
  input wire logic [15:0] run_control_setting_word_in,
  input wire logic [15:0] motion_command_word_in,
  input wire logic wrap_req_in,
  input wire logic one_dir_req_in,
  input wire logic abs_enc_in,
  input wire logic at_target_in,
  input wire logic servo_on_in,
  output logic cmd_active_out,
  output logic [15:0] motion_command_word_out,
  output logic [3:0] ref_unit_out,
  output logic [2:0] ref_digits_out,
  output logic unit_err_out,
  output logic wrap_en_out,
  output logic wrap_refused_out,
  output logic one_dir_en_out,
  output logic incr_mode_out,
  output logic monitor_ref_unit_out,
  output logic gear_en_out,
  output logic pos_buffer_en_out,
  output logic [1:0] servo_state_out,
  output logic clamp_out,
  output logic zero_ret_needed_out
);

  // ----------------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------------
  if (DIGITS_W != APM_DIGITS_W) begin : g_bad_width
    $error("digit field width must be three");
  end

  // ----------------------------------------------------------------------
  // pin inputs through two flops
  // ----------------------------------------------------------------------
  logic [2:0] pins_s;

  apm_sync #(
    .WIDTH(3)
  ) u_sync (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .async_in({abs_enc_in, at_target_in, servo_on_in}),
    .sync_out(pins_s)
  );

  wire abs_enc_s = pins_s[2];
  wire at_target_s = pins_s[1];
  wire servo_on_s = pins_s[0];

  // ----------------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------------
  // either bit low means the axis ignores the command word
  wire next_cmd = fixed_add_func_in[APM_SEL_BIT]
                  & run_mode_setting_word_in[APM_CODE_EN_BIT];
  wire [3:0] unit_field = fixed_func_flags_in[APM_UNIT_LSB +: APM_UNIT_W];
  wire unit_legal = (unit_field <= APM_UNIT_INCH);
  // unknown codes fall back to pulse rather than guessing a scale
  wire [3:0] next_unit = (next_cmd && unit_legal) ? unit_field
                                                  : APM_UNIT_PULSE;
  wire digits_legal = (fixed_digits_in <= APM_DIGITS_MAX);
  wire [2:0] digits_clip = digits_legal ? fixed_digits_in : APM_DIGITS_MAX;
  // pulse has no fractional scale
  wire [2:0] next_digits = (next_unit == APM_UNIT_PULSE) ? 3'h0
                                                         : digits_clip;
  wire next_unit_err = next_cmd && (!unit_legal || !digits_legal);
  wire next_wrap = wrap_req_in & next_cmd;
  wire next_refused = wrap_req_in & ~next_cmd;
  wire next_incr = next_cmd & run_control_setting_word_in[APM_REFTYPE_BIT];
  // gear is also off for pulse units
  wire next_gear = next_cmd & fixed_func_flags_in[APM_GEAR_BIT]
                   & (next_unit != APM_UNIT_PULSE);

  // ----------------------------------------------------------------------
  // registered mode outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cmd_active_out <= 1'b0;
      motion_command_word_out <= 16'h0000;
      ref_unit_out <= APM_RST_UNIT;
      ref_digits_out <= APM_RST_DIGITS;
      unit_err_out <= 1'b0;
      wrap_en_out <= 1'b0;
      wrap_refused_out <= 1'b0;
      one_dir_en_out <= 1'b0;
      incr_mode_out <= 1'b0;
      monitor_ref_unit_out <= 1'b0;
      gear_en_out <= 1'b0;
      pos_buffer_en_out <= 1'b0;
    end else begin
      cmd_active_out <= next_cmd;
      // command word is passed on only in command mode
      motion_command_word_out <= next_cmd ? motion_command_word_in : 16'h0000;
      ref_unit_out <= next_unit;
      ref_digits_out <= next_digits;
      unit_err_out <= next_unit_err;
      wrap_en_out <= next_wrap;
      wrap_refused_out <= next_refused;
      one_dir_en_out <= one_dir_req_in;
      incr_mode_out <= next_incr;
      monitor_ref_unit_out <= next_cmd;
      gear_en_out <= next_gear;
      pos_buffer_en_out <= next_cmd;
    end
  end

  // ----------------------------------------------------------------------
  // servo state: move, stop at target, clamp
  // ----------------------------------------------------------------------
  apm_state_t state;
  apm_state_t next_state;

  always_comb begin
    next_state = state;
    case (state)
      APM_ST_IDLE: if (servo_on_s) next_state = at_target_s ? APM_ST_CLAMP : APM_ST_MOVE;
      APM_ST_MOVE: begin
        if (!servo_on_s) next_state = APM_ST_IDLE;
        else if (at_target_s) next_state = APM_ST_CLAMP;
      end
      APM_ST_CLAMP: begin
        if (!servo_on_s) next_state = APM_ST_IDLE;
        else if (!at_target_s) next_state = APM_ST_MOVE;
      end
      default: next_state = APM_ST_IDLE;
    endcase
  end

  // clamp and zero-return flags registered with the state
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state <= APM_ST_IDLE;
      servo_state_out <= 2'b00;
      clamp_out <= 1'b0;
      zero_ret_needed_out <= 1'b1;
    end else begin
      state <= next_state;
      servo_state_out <= next_state;
      clamp_out <= (next_state == APM_ST_CLAMP);
      // absolute position survives power loss, so no return needed
      zero_ret_needed_out <= ~abs_enc_s;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  a_cmd_gate: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    next_cmd |=> cmd_active_out && monitor_ref_unit_out && pos_buffer_en_out)
    else $error("command mode not entered");
  a_cmd_word: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    next_cmd |=> motion_command_word_out == $past(motion_command_word_in))
    else $error("command word not passed on");
  a_cmd_block: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    !next_cmd |=> !cmd_active_out && motion_command_word_out == 16'h0000)
    else $error("command word used without both enables");
  a_pulse_forced: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    !cmd_active_out |-> ref_unit_out == APM_UNIT_PULSE && ref_digits_out == 3'h0)
    else $error("unit not pulse without commands");
  a_unit_decode: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    next_cmd && unit_legal |=> ref_unit_out == $past(unit_field))
    else $error("unit code not decoded");
  a_digit_scale: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    next_cmd && unit_legal && digits_legal && unit_field != APM_UNIT_PULSE
    |=> ref_digits_out == $past(fixed_digits_in))
    else $error("digits not applied to unit");
  a_wrap_refuse: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    !cmd_active_out |-> !wrap_en_out && !incr_mode_out && !gear_en_out)
    else $error("command-only feature without commands");
  a_wrap_flag: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    wrap_req_in && !next_cmd |=> wrap_refused_out && !wrap_en_out)
    else $error("wrap request not refused");
  a_one_dir: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    one_dir_req_in |=> one_dir_en_out)
    else $error("one-direction mode refused");
  a_incr_sel: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    next_cmd && run_control_setting_word_in[APM_REFTYPE_BIT] |=> incr_mode_out)
    else $error("incremental mode not selected");
  a_pulse_monitor: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    !next_cmd |=> !monitor_ref_unit_out && !pos_buffer_en_out)
    else $error("reference monitor or buffer without commands");
  a_clamp_hold: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    state == APM_ST_MOVE && servo_on_s && at_target_s |=> clamp_out)
    else $error("no clamp at target");
  a_servo_off: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    !servo_on_s |=> servo_state_out == APM_ST_IDLE && !clamp_out)
    else $error("clamp held with servo off");
  a_abs_enc: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    abs_enc_s |=> !zero_ret_needed_out)
    else $error("zero return asked with absolute encoder");
  a_inc_enc: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    !abs_enc_s |=> zero_ret_needed_out)
    else $error("zero return not asked with incremental encoder");

endmodule : apm_mode_cfg

//--- tb/apm_axis_model.sv
/*
  Behavioural servo axis with encoder, facing the position mode block.
  Assumes the bench drives servo on, new-target and encoder-kind controls.
*/
`timescale 1ns/10ps
module apm_axis_model #(
  parameter int MOVE_CYC = 6
) (
  input wire logic mclk_in,
  input wire logic servo_on_in,
  input wire logic new_target_in,
  input wire logic abs_fit_in,
  output logic abs_enc_out,
  output logic at_target_out
);
  int cnt = 0;
  logic reached = 1'b0;

  // ------------------------------------------------------------------
  // encoder kind and travel to target
  // ------------------------------------------------------------------
  assign abs_enc_out = abs_fit_in;
  assign at_target_out = reached;

  // a new target or servo off restarts the travel, so target is lost at once
  always @(posedge mclk_in) begin
    if (!servo_on_in || new_target_in) cnt <= 0;
    else if (cnt < MOVE_CYC) cnt <= cnt + 1;
    reached <= servo_on_in && !new_target_in && cnt >= MOVE_CYC - 1;
  end
endmodule : apm_axis_model

//--- tb/tb_top.sv
/*
  Self-checking bench for the position mode block with an axis model.
  Assumes decode latency of one edge and pin latency of three edges.
*/
`timescale 1ns/10ps
module tb_top
  import apm_pkg::*;
;
  typedef struct {int due; logic [31:0] val;} apm_note_t;
  logic mclk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [15:0] af = '0, fl = '0, mw = '0, cw = '0, mc = '0;
  logic [2:0] dg = '0;
  logic wr = 1'b0, od = 1'b0, servo_on = 1'b0, new_tgt = 1'b0, abs_fit = 1'b0;
  logic abs_enc, at_target;
  logic [31:0] dec_out, r, r2;
  logic [3:0] pin_out;
  int cyc = 0, fail_count = 0, comparisons = 0, seed = 14;
  apm_note_t qd[$], qp[$];

  always #12.5 mclk_in = ~mclk_in;

  apm_mode_cfg uut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .fixed_add_func_in(af),
    .fixed_func_flags_in(fl), .fixed_digits_in(dg), .run_mode_setting_word_in(mw),
    .run_control_setting_word_in(cw), .motion_command_word_in(mc), .wrap_req_in(wr),
    .one_dir_req_in(od), .abs_enc_in(abs_enc), .at_target_in(at_target),
    .servo_on_in(servo_on), .cmd_active_out(dec_out[31]),
    .motion_command_word_out(dec_out[30:15]), .ref_unit_out(dec_out[14:11]),
    .ref_digits_out(dec_out[10:8]), .unit_err_out(dec_out[7]), .wrap_en_out(dec_out[6]),
    .wrap_refused_out(dec_out[5]), .one_dir_en_out(dec_out[4]), .incr_mode_out(dec_out[3]),
    .monitor_ref_unit_out(dec_out[2]), .gear_en_out(dec_out[1]),
    .pos_buffer_en_out(dec_out[0]), .servo_state_out(pin_out[3:2]), .clamp_out(pin_out[1]),
    .zero_ret_needed_out(pin_out[0]));

  apm_axis_model axis (.mclk_in(mclk_in), .servo_on_in(servo_on), .new_target_in(new_tgt),
    .abs_fit_in(abs_fit), .abs_enc_out(abs_enc), .at_target_out(at_target));

  // ------------------------------------------------------------------
  // expectations, comparisons and closing
  // ------------------------------------------------------------------
  // illegal unit codes fall back to pulse, and pulse carries no digits
  function automatic logic [31:0] exp_dec();
    logic act, bad;
    logic [3:0] u;
    act = af[APM_SEL_BIT] & mw[APM_CODE_EN_BIT];
    bad = fl[3:0] > 4'h3;
    u = (act && !bad) ? fl[3:0] : 4'h0;
    return {act, act ? mc : 16'h0000, u, (u == 4'h0) ? 3'h0 : (dg > 3'h5 ? 3'h5 : dg),
      act & (bad | (dg > 3'h5)), act & wr, !act & wr, od, act & cw[APM_REFTYPE_BIT], act,
      act & fl[APM_GEAR_BIT] & (u != 4'h0), act};
  endfunction : exp_dec

  task automatic cmp_dec(input logic [31:0] exp);
    comparisons++;
    if (dec_out !== exp) begin
      fail_count++;
      $display("[ERR] %0t decode got %h exp %h", $time, dec_out, exp);
    end
  endtask : cmp_dec

  task automatic cmp_pin(input logic [3:0] exp);
    comparisons++;
    if (pin_out !== exp) begin
      fail_count++;
      $display("[ERR] %0t servo got %h exp %h", $time, pin_out, exp);
    end
  endtask : cmp_pin

  task automatic end_sim();
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  // driver: set words just after the edge, note the result due one edge later
  task automatic apply(input logic [15:0] a, f, m, c, w, input logic [2:0] d, input logic q, o);
    af = a; fl = f; mw = m; cw = c; mc = w; dg = d; wr = q; od = o;
    qd.push_back('{cyc + 1, exp_dec()});
    @(posedge mclk_in);
    #1;
  endtask : apply

  // cycle count and hang guard; the run needs well under 400 edges
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (cyc >= 1000) begin
      fail_count++;
      end_sim();
    end
  end

  // monitor: pins are noted here since the axis model drives them
  // pins pass the sync stages and then the state flop before they show
  always @(negedge mclk_in) begin
    if (!sys_rst_in) qp.push_back('{cyc + APM_POS_LAT + 1,
      {28'h0, servo_on ? (at_target ? 2'h2 : 2'h1) : 2'h0, servo_on & at_target, !abs_enc}});
    if (qd.size() > 0 && qd[0].due == cyc) begin
      cmp_dec(qd[0].val);
      void'(qd.pop_front());
    end
    if (qp.size() > 0 && qp[0].due == cyc) begin
      cmp_pin(qp[0].val[3:0]);
      void'(qp.pop_front());
    end
  end

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (3) @(posedge mclk_in);
    #1;
    cmp_pin(4'h1);
    cmp_dec(32'h0000_0000);
    sys_rst_in = 1'b0;
    // every enable pair, every unit code 0..7, digits 0..7, random other bits
    for (int i = 0; i < 256; i++) begin
      r = $random(seed);
      r2 = $random(seed);
      r[APM_SEL_BIT] = i[0];
      r[16 + APM_CODE_EN_BIT] = i[1];
      apply(r[15:0], {r[31:21], r2[4], 1'b0, i[4:2]}, r[31:16], r2[15:0], r2[31:16], i[7:5],
        r2[0], r2[1]);
    end
    // motion programs: program sets incremental reference type
    apply(16'h0080, 16'h0012, 16'h0100, 16'h4000, 16'hA5C3, 3'h5, 1'b1, 1'b1);
    apply(16'h0080, 16'h0013, 16'h0000, 16'h4000, 16'hA5C3, 3'h2, 1'b1, 1'b0);
    servo_on = 1'b1;
    repeat (14) @(posedge mclk_in);
    #1 new_tgt = 1'b1;
    @(posedge mclk_in);
    #1 new_tgt = 1'b0;
    repeat (14) @(posedge mclk_in);
    #1 servo_on = 1'b0;
    repeat (6) @(posedge mclk_in);
    #1 abs_fit = 1'b1;
    repeat (8) @(posedge mclk_in);
    end_sim();
  end
endmodule : tb_top
